// *** pic_pkg.sv ***
// Package with constants and types for the priority interrupt controller
package pic_pkg;

  localparam int NUM_SRC = 128;
  localparam int SRC_W = 7;
  localparam int LVL_W = 3;
  localparam int NUM_W = 8;
  localparam int WAKE_LIMIT = 96;

  localparam logic [11:0] CTRL_BASE_OFF = 12'h000;
  localparam logic [11:0] CTRL_END_OFF = 12'h200;
  localparam logic [11:0] FLAG_OFF = 12'h200;
  localparam logic [11:0] VBASE_OFF = 12'h204;
  localparam logic [11:0] WAKE_A_OFF = 12'h208;
  localparam logic [11:0] WAKE_B_OFF = 12'h20c;
  localparam logic [11:0] STAT_OFF = 12'h210;

  localparam int CTRL_LVL_LSB = 0;
  localparam int CTRL_PEND_BIT = 3;
  localparam int FLAG_GIE_BIT = 0;
  localparam int FLAG_PPL_LSB = 4;
  localparam int WAKE_LVL_LSB = 0;
  localparam int WAKE_FAST_BIT = 3;
  localparam int WAKE_DMA_BIT = 4;
  localparam int STAT_LVL_LSB = 8;
  localparam int STAT_VALID_BIT = 11;

  localparam logic [2:0] PPL_RST = 3'h0;
  localparam logic [2:0] LVL_RST = 3'h0;
  localparam logic [2:0] LVL_TOP = 3'h7;
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic [4:0] WAKE_RST = 5'h00;
  localparam logic [31:0] VBASE_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_READ = 4'b0100,
    BUS_DONE = 4'b1000
  } pic_bus_e;

endpackage

// *** pic_resolver.sv ***
// Priority resolver picking the highest-level eligible source
`timescale 1ns/1ps
module pic_resolver (
  input wire logic [pic_pkg::NUM_SRC-1:0] elig_in,
  input wire logic [pic_pkg::NUM_SRC*pic_pkg::LVL_W-1:0] lvl_in,
  output logic valid_out,
  output logic [pic_pkg::SRC_W-1:0] num_out,
  output logic [pic_pkg::LVL_W-1:0] lvl_out
);

  logic [pic_pkg::LVL_W-1:0] cur;

  // Higher level wins; on equal level the lower source index wins
  always_comb begin
    valid_out = 1'b0;
    num_out = '0;
    lvl_out = '0;
    cur = '0;
    for (int i = pic_pkg::NUM_SRC - 1; i >= 0; i--) begin
      cur = lvl_in[i*pic_pkg::LVL_W +: pic_pkg::LVL_W];
      if (elig_in[i] && (!valid_out || cur >= lvl_out)) begin
        valid_out = 1'b1;
        num_out = pic_pkg::SRC_W'(i);
        lvl_out = cur;
      end
    end
  end

endmodule

// *** pic_top.sv ***
// Priority interrupt controller with AHB-Lite register access
`timescale 1ns/1ps
module pic_top (
  input wire logic CORE_CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic [pic_pkg::NUM_SRC-1:0] SRC_REQ_IN,
  input wire logic SW_INT_IN,
  input wire logic [pic_pkg::NUM_W-1:0] SW_INT_NUM_IN,
  input wire logic SPECIAL_REQ_IN,
  input wire logic ACK_IN,
  input wire logic DMA_ACK_IN,
  output logic IRQ_OUT,
  output logic [pic_pkg::NUM_W-1:0] IRQ_NUM_OUT,
  output logic [pic_pkg::LVL_W-1:0] IRQ_LEVEL_OUT,
  output logic [31:0] IRQ_VECTOR_OUT,
  output logic FAST_IRQ_OUT,
  output logic SW_TAKE_OUT,
  output logic [31:0] SW_VECTOR_OUT,
  output logic SPECIAL_TAKE_OUT,
  output logic DMA_REQ_OUT,
  output logic [pic_pkg::NUM_W-1:0] DMA_NUM_OUT,
  output logic WAKE_OUT
);

  localparam int N = pic_pkg::NUM_SRC;
  localparam int LW = pic_pkg::LVL_W;

  pic_pkg::pic_bus_e bus_q, bus_d;
  logic [11:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic addr_take;

  logic [LW-1:0] lvl_q [N];
  logic [LW-1:0] lvl_d [N];
  logic [N-1:0] pend_q, pend_d;
  logic gie_q, gie_d;
  logic [LW-1:0] ppl_q, ppl_d;
  logic [31:0] vbase_q, vbase_d;
  logic [4:0] wake_a_q, wake_a_d;
  logic [4:0] wake_b_q, wake_b_d;

  logic irq_q, irq_d;
  logic [pic_pkg::SRC_W-1:0] irq_num_q, irq_num_d;
  logic [LW-1:0] irq_lvl_q, irq_lvl_d;
  logic [31:0] irq_vec_q, irq_vec_d;
  logic fast_q, fast_d;
  logic sw_q, sw_d;
  logic [31:0] sw_vec_q, sw_vec_d;
  logic spec_q, spec_d;
  logic dma_q, dma_d;
  logic [pic_pkg::SRC_W-1:0] dma_num_q, dma_num_d;
  logic wake_q, wake_d;

  logic [N-1:0] cpu_elig, dma_elig;
  logic [N*LW-1:0] lvl_flat;
  logic cpu_valid, dma_valid;
  logic [pic_pkg::SRC_W-1:0] cpu_num, dma_num;
  logic [LW-1:0] cpu_lvl, dma_lvl;
  logic fast_sel, dma_sel;
  logic ack_take, dma_ack_take;

  // Vector entry address for an interrupt number
  function automatic logic [31:0] vec_addr(input logic [31:0] base,
                                           input logic [pic_pkg::NUM_W-1:0] num);
    vec_addr = base + {22'h000000, num, 2'b00};
  endfunction

  assign fast_sel = wake_a_q[pic_pkg::WAKE_FAST_BIT];
  assign dma_sel = wake_a_q[pic_pkg::WAKE_DMA_BIT];
  assign ack_take = ACK_IN && irq_q;
  assign dma_ack_take = DMA_ACK_IN && dma_q;

  // Eligibility for the processor and for the DMA handoff
  always_comb begin
    for (int i = 0; i < N; i++) begin
      lvl_flat[i*LW +: LW] = lvl_q[i];
      cpu_elig[i] = gie_q && !dma_sel && pend_q[i] &&
                    (lvl_q[i] > ppl_q);
      dma_elig[i] = dma_sel && pend_q[i] && (lvl_q[i] != pic_pkg::LVL_OFF);
    end
  end

  pic_resolver u_cpu_res (
    .elig_in(cpu_elig),
    .lvl_in(lvl_flat),
    .valid_out(cpu_valid),
    .num_out(cpu_num),
    .lvl_out(cpu_lvl)
  );

  pic_resolver u_dma_res (
    .elig_in(dma_elig),
    .lvl_in(lvl_flat),
    .valid_out(dma_valid),
    .num_out(dma_num),
    .lvl_out(dma_lvl)
  );

  // AHB-Lite slave: writes zero-wait, reads with one wait state
  assign addr_take = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

  always_comb begin
    bus_d = bus_q;
    addr_d = addr_q;
    hrdata_d = hrdata_q;
    case (bus_q)
      pic_pkg::BUS_READ: begin
        hrdata_d = 32'h0000_0000;
        if (addr_q < pic_pkg::CTRL_END_OFF) begin
          hrdata_d[pic_pkg::CTRL_PEND_BIT] = pend_q[addr_q[8:2]];
          hrdata_d[pic_pkg::CTRL_LVL_LSB +: LW] = lvl_q[addr_q[8:2]];
        end else if (addr_q == pic_pkg::FLAG_OFF) begin
          hrdata_d[pic_pkg::FLAG_GIE_BIT] = gie_q;
          hrdata_d[pic_pkg::FLAG_PPL_LSB +: LW] = ppl_q;
        end else if (addr_q == pic_pkg::VBASE_OFF) begin
          hrdata_d = vbase_q;
        end else if (addr_q == pic_pkg::WAKE_A_OFF) begin
          hrdata_d[4:0] = wake_a_q;
        end else if (addr_q == pic_pkg::WAKE_B_OFF) begin
          hrdata_d[4:0] = wake_b_q;
        end else if (addr_q == pic_pkg::STAT_OFF) begin
          hrdata_d[pic_pkg::SRC_W-1:0] = irq_num_q;
          hrdata_d[pic_pkg::STAT_LVL_LSB +: LW] = irq_lvl_q;
          hrdata_d[pic_pkg::STAT_VALID_BIT] = irq_q;
        end
        bus_d = pic_pkg::BUS_DONE;
      end
      pic_pkg::BUS_IDLE, pic_pkg::BUS_WRITE, pic_pkg::BUS_DONE: begin
        if (addr_take) begin
          addr_d = HADDR_IN[11:0];
          bus_d = HWRITE_IN ? pic_pkg::BUS_WRITE : pic_pkg::BUS_READ;
        end else begin
          bus_d = pic_pkg::BUS_IDLE;
        end
      end
      default: begin
        bus_d = pic_pkg::BUS_IDLE;
      end
    endcase
  end

  assign HREADYOUT_OUT = (bus_q != pic_pkg::BUS_READ);
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = hrdata_q;

  // Register state, pending flags and processor-facing outputs
  always_comb begin
    gie_d = gie_q;
    ppl_d = ppl_q;
    vbase_d = vbase_q;
    wake_a_d = wake_a_q;
    wake_b_d = wake_b_q;
    pend_d = pend_q;
    for (int i = 0; i < N; i++) begin
      lvl_d[i] = lvl_q[i];
    end
    if (bus_q == pic_pkg::BUS_WRITE) begin
      if (addr_q < pic_pkg::CTRL_END_OFF) begin
        lvl_d[addr_q[8:2]] = HWDATA_IN[pic_pkg::CTRL_LVL_LSB +: LW];
        pend_d[addr_q[8:2]] = pend_q[addr_q[8:2]] &&
                              HWDATA_IN[pic_pkg::CTRL_PEND_BIT];
      end else if (addr_q == pic_pkg::FLAG_OFF) begin
        gie_d = HWDATA_IN[pic_pkg::FLAG_GIE_BIT];
        ppl_d = HWDATA_IN[pic_pkg::FLAG_PPL_LSB +: LW];
      end else if (addr_q == pic_pkg::VBASE_OFF) begin
        vbase_d = HWDATA_IN;
      end else if (addr_q == pic_pkg::WAKE_A_OFF) begin
        wake_a_d = HWDATA_IN[4:0];
      end else if (addr_q == pic_pkg::WAKE_B_OFF) begin
        wake_b_d = HWDATA_IN[4:0];
      end
    end
    if (ack_take) begin
      pend_d[irq_num_q] = 1'b0;
      ppl_d = irq_lvl_q;
    end
    if (dma_ack_take) begin
      pend_d[dma_num_q] = 1'b0;
    end
    // A new request beats any clear in the same cycle
    pend_d = pend_d | SRC_REQ_IN;

    irq_d = cpu_valid && !ack_take;
    irq_num_d = cpu_num;
    irq_lvl_d = cpu_lvl;
    irq_vec_d = vec_addr(vbase_q, {1'b0, cpu_num});
    fast_d = cpu_valid && !ack_take && fast_sel && (cpu_lvl == pic_pkg::LVL_TOP);
    dma_d = dma_valid && !dma_ack_take;
    dma_num_d = dma_num;
    sw_d = SW_INT_IN;
    sw_vec_d = SW_INT_IN ? vec_addr(vbase_q, SW_INT_NUM_IN) : sw_vec_q;
    spec_d = SPECIAL_REQ_IN;
    wake_d = 1'b0;
    for (int i = 0; i < pic_pkg::WAKE_LIMIT; i++) begin
      if (pend_q[i] && lvl_q[i] > wake_a_q[pic_pkg::WAKE_LVL_LSB +: LW]) begin
        wake_d = 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bus_q <= pic_pkg::BUS_IDLE;
      addr_q <= 12'h000;
      hrdata_q <= 32'h0000_0000;
      gie_q <= 1'b0;
      ppl_q <= pic_pkg::PPL_RST;
      vbase_q <= pic_pkg::VBASE_RST;
      wake_a_q <= pic_pkg::WAKE_RST;
      wake_b_q <= pic_pkg::WAKE_RST;
      pend_q <= '0;
      for (int i = 0; i < N; i++) begin
        lvl_q[i] <= pic_pkg::LVL_RST;
      end
      irq_q <= 1'b0;
      irq_num_q <= '0;
      irq_lvl_q <= '0;
      irq_vec_q <= 32'h0000_0000;
      fast_q <= 1'b0;
      dma_q <= 1'b0;
      dma_num_q <= '0;
      sw_q <= 1'b0;
      sw_vec_q <= 32'h0000_0000;
      spec_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (CLK_EN_IN) begin
      bus_q <= bus_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      gie_q <= gie_d;
      ppl_q <= ppl_d;
      vbase_q <= vbase_d;
      wake_a_q <= wake_a_d;
      wake_b_q <= wake_b_d;
      pend_q <= pend_d;
      for (int i = 0; i < N; i++) begin
        lvl_q[i] <= lvl_d[i];
      end
      irq_q <= irq_d;
      irq_num_q <= irq_num_d;
      irq_lvl_q <= irq_lvl_d;
      irq_vec_q <= irq_vec_d;
      fast_q <= fast_d;
      dma_q <= dma_d;
      dma_num_q <= dma_num_d;
      sw_q <= sw_d;
      sw_vec_q <= sw_vec_d;
      spec_q <= spec_d;
      wake_q <= wake_d;
    end
  end

  assign IRQ_OUT = irq_q;
  assign IRQ_NUM_OUT = {1'b0, irq_num_q};
  assign IRQ_LEVEL_OUT = irq_lvl_q;
  assign IRQ_VECTOR_OUT = irq_vec_q;
  assign FAST_IRQ_OUT = fast_q;
  assign SW_TAKE_OUT = sw_q;
  assign SW_VECTOR_OUT = sw_vec_q;
  assign SPECIAL_TAKE_OUT = spec_q;
  assign DMA_REQ_OUT = dma_q;
  assign DMA_NUM_OUT = {1'b0, dma_num_q};
  assign WAKE_OUT = wake_q;

  grant_enable_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    irq_q && $past(CLK_EN_IN) |-> $past(gie_q) && !$past(dma_sel))
    else $error("Request granted without enable");
  grant_level_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    irq_q && $past(CLK_EN_IN) && !$past(ack_take) |-> irq_lvl_q > $past(ppl_q))
    else $error("Granted level not above priority");
  ppl_top_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && ppl_q == 3'h7 |=> !irq_q)
    else $error("Request granted at top priority");
  zero_level_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    irq_q || dma_q |-> irq_lvl_q != 3'h0 || !irq_q)
    else $error("Level zero source granted");
  ack_ppl_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && ACK_IN && irq_q |=> ppl_q == $past(irq_lvl_q) && !irq_q)
    else $error("Priority not loaded on acknowledge");
  ack_clear_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && ACK_IN && irq_q && !SRC_REQ_IN[irq_num_q] |=> !pend_q[$past(irq_num_q)])
    else $error("Pending not cleared on acknowledge");
  req_set_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && SRC_REQ_IN[0] |=> pend_q[0] ##1 (pend_q[0] || !$past(CLK_EN_IN) ||
    $past(ack_take) || $past(dma_ack_take) || $past(bus_q == pic_pkg::BUS_WRITE)))
    else $error("Request lost");
  sw_vec_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    CLK_EN_IN && SW_INT_IN |=> sw_q && SW_VECTOR_OUT == $past(vbase_q) +
    {22'h000000, $past(SW_INT_NUM_IN), 2'b00})
    else $error("Software vector address wrong");
  fast_sel_a: assert property (@(posedge CORE_CLK_IN) disable iff (RST_IN)
    FAST_IRQ_OUT |-> irq_q && irq_lvl_q == 3'h7)
    else $error("Fast interrupt below level seven");

endmodule

// *** pic_cpu_model.sv ***
// Processor model that acknowledges offered requests
`timescale 1ns/1ps
module pic_cpu_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic stall_in,
  input wire logic [2:0] delay_in,
  input wire logic irq_in,
  input wire logic dma_req_in,
  output logic ack_out,
  output logic dma_ack_out
);
  logic [2:0] wait_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_out <= 1'b0;
      dma_ack_out <= 1'b0;
      wait_q <= 3'h0;
    end else if (ack_out || dma_ack_out) begin
      ack_out <= 1'b0; // One-cycle acknowledge
      dma_ack_out <= 1'b0;
      wait_q <= 3'h0;
    end else if ((irq_in || dma_req_in) && !stall_in) begin
      if (wait_q >= delay_in) begin
        ack_out <= irq_in; // Taken while the offer stands
        dma_ack_out <= dma_req_in;
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ps
module tb_top;
  logic clk, rst, hw, sw, sp, stall, hro, hrs, irq, fast, stake, sptake, dreq, wake, ack, dack;
  logic en;
  logic [1:0] ht;
  logic [11:0] ha;
  logic [31:0] wd, rdv, hrd, ivec, svec, vb;
  logic [127:0] req;
  logic [7:0] swn, inum, dnum;
  logic [2:0] ilvl, dly;
  int n_mismatch = 0;
  int checked = 0;
  int s, lv, pl;
  int nums[3] = '{0, 96, 255};
  pic_top i_dut (
    .CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(en), .HSEL_IN(1'b1),
    .HADDR_IN({20'h0, ha}), .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(3'h2),
    .HWDATA_IN(wd), .HREADY_IN(hro), .HRDATA_OUT(hrd), .HREADYOUT_OUT(hro),
    .HRESP_OUT(hrs), .SRC_REQ_IN(req), .SW_INT_IN(sw), .SW_INT_NUM_IN(swn),
    .SPECIAL_REQ_IN(sp), .ACK_IN(ack), .DMA_ACK_IN(dack), .IRQ_OUT(irq),
    .IRQ_NUM_OUT(inum), .IRQ_LEVEL_OUT(ilvl), .IRQ_VECTOR_OUT(ivec),
    .FAST_IRQ_OUT(fast), .SW_TAKE_OUT(stake), .SW_VECTOR_OUT(svec),
    .SPECIAL_TAKE_OUT(sptake), .DMA_REQ_OUT(dreq), .DMA_NUM_OUT(dnum), .WAKE_OUT(wake)
  );
  pic_cpu_model i_cpu (
    .clk_in(clk), .rst_in(rst), .stall_in(stall), .delay_in(dly),
    .irq_in(irq), .dma_req_in(dreq), .ack_out(ack), .dma_ack_out(dack)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task stop_test;
    if (n_mismatch == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tmo(inout int n);
    n++;
    if (n > 40) begin
      n_mismatch++;
      stop_test;
    end
  endtask
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    ht <= 2'h2;
    ha <= a;
    hw <= w;
    @(negedge clk);
    while (hro !== 1'b1) begin
      tmo(n);
      @(negedge clk);
    end
    @(posedge clk);
    ht <= 2'h0;
    wd <= d;
    @(negedge clk);
    while (hro !== 1'b1) begin
      tmo(n);
      @(negedge clk);
    end
    @(posedge clk);
    rdv = hrd;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("hrdata", rdv, e);
  endtask
  function automatic logic [11:0] ctl(input int n);
    return 12'(4 * n);
  endfunction
  task pulse(input logic [127:0] m);
    @(posedge clk);
    req <= m; // Single-cycle request, as from one-edge detection
    @(posedge clk);
    req <= '0;
  endtask
  task settle;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task serve;
    int n;
    n = 0;
    @(posedge clk);
    stall <= 1'b0;
    @(negedge clk);
    while (irq === 1'b1 || dreq === 1'b1) begin
      tmo(n);
      @(negedge clk);
    end
    @(posedge clk);
    stall <= 1'b1;
  endtask
  initial begin
    rst = 1'b1; hw = 1'b0; sw = 1'b0; sp = 1'b0; stall = 1'b1;
    en = 1'b1;
    ht = 2'h0; ha = 12'h0; wd = 32'h0; req = '0; swn = 8'h0; dly = 3'h0;
    void'($urandom(80077));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(pic_pkg::FLAG_OFF, 32'h0);
    rd(pic_pkg::VBASE_OFF, 32'h0);
    rd(ctl(127), 32'h0);
    bus(1'b1, 12'h300, 32'hffff_ffff);
    rd(12'h300, 32'h0);
    for (int i = 0; i < 16; i++) begin
      s = $urandom_range(95, 0);
      lv = $urandom_range(7, 0);
      pl = $urandom_range(7, 0);
      if (i == 0) begin lv = 7; pl = 6; end
      if (i == 1) begin lv = 0; pl = 0; end
      if (i == 2) begin lv = 7; pl = 7; end
      vb = $urandom & 32'hffff_fffc;
      dly <= 3'($urandom_range(4, 0));
      bus(1'b1, pic_pkg::FLAG_OFF, 32'h0);
      bus(1'b1, pic_pkg::VBASE_OFF, vb);
      bus(1'b1, ctl(s), lv);
      rd(ctl(s), lv);
      bus(1'b1, pic_pkg::FLAG_OFF, (pl << 4) | 1);
      pulse(128'h1 << s);
      settle;
      chk("irq", irq, lv > pl);
      if (lv > pl) begin
        chk("irq num", inum, s);
        chk("irq level", ilvl, lv);
        chk("irq vector", ivec, vb + 4 * s);
        rd(pic_pkg::STAT_OFF, 32'h800 | (lv << 8) | s);
        serve;
        rd(pic_pkg::FLAG_OFF, (lv << 4) | 1);
        rd(ctl(s), lv);
      end else begin
        rd(ctl(s), 8 | lv);
        bus(1'b1, ctl(s), 32'h0);
        bus(1'b1, ctl(s), 8 | lv);
        rd(ctl(s), lv);
      end
    end
    bus(1'b1, pic_pkg::FLAG_OFF, 32'h0);
    bus(1'b1, ctl(9), 32'h4);
    bus(1'b1, ctl(3), 32'h4);
    bus(1'b1, ctl(40), 32'h5);
    bus(1'b1, pic_pkg::FLAG_OFF, 32'h1);
    pulse((128'h1 << 9) | (128'h1 << 3) | (128'h1 << 40));
    settle;
    chk("irq num", inum, 40);
    serve;
    bus(1'b1, pic_pkg::FLAG_OFF, 32'h1);
    settle;
    chk("irq num", inum, 3);
    serve;
    bus(1'b1, pic_pkg::FLAG_OFF, 32'h0);
    bus(1'b1, ctl(9), 32'h0);
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      sw <= 1'b1;
      sp <= 1'b1;
      swn <= 8'(nums[j]);
      @(posedge clk);
      sw <= 1'b0;
      sp <= 1'b0;
      @(negedge clk);
      chk("sw take", stake, 1);
      chk("special take", sptake, 1);
      chk("sw vector", svec, vb + 4 * nums[j]);
    end
    bus(1'b1, pic_pkg::WAKE_A_OFF, 32'h2);
    bus(1'b1, pic_pkg::WAKE_B_OFF, 32'h2);
    bus(1'b1, ctl(5), 32'h2);
    pulse(128'h1 << 5);
    settle;
    chk("wake", wake, 0);
    bus(1'b1, ctl(5), 32'hb);
    settle;
    chk("wake", wake, 1);
    bus(1'b1, ctl(5), 32'h0);
    bus(1'b1, ctl(100), 32'h7);
    pulse(128'h1 << 100);
    settle;
    chk("wake", wake, 0);
    bus(1'b1, pic_pkg::WAKE_A_OFF, 32'ha);
    bus(1'b1, pic_pkg::WAKE_B_OFF, 32'ha);
    bus(1'b1, pic_pkg::FLAG_OFF, 32'h1);
    settle;
    chk("fast", fast, 1);
    @(posedge clk);
    en <= 1'b0;
    stall <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("irq held", irq, 1);
    chk("fast held", fast, 1);
    @(posedge clk);
    en <= 1'b1;
    serve;
    bus(1'b1, pic_pkg::FLAG_OFF, 32'h70);
    bus(1'b1, pic_pkg::WAKE_A_OFF, 32'h10);
    bus(1'b1, pic_pkg::WAKE_B_OFF, 32'h10);
    bus(1'b1, ctl(7), 32'h1);
    pulse(128'h1 << 7);
    settle;
    chk("dma req", dreq, 1);
    chk("dma num", dnum, 7);
    chk("irq", irq, 0);
    serve;
    rd(ctl(7), 32'h1);
    chk("hresp", hrs, 0);
    rd(pic_pkg::WAKE_B_OFF, 32'h10);
    stop_test;
  end
endmodule
